//--- logic/ofd_defs.svh
// Constants for the operand field decoder
`ifndef OFD_DEFS_SVH
`define OFD_DEFS_SVH
`define OFD_INSN_W 14
`define OFD_DATA_W 8
`define OFD_FADDR_W 7
`define OFD_FADDR_LSB 0
`define OFD_DEST_POS 7
`define OFD_BIT_LSB 7
`define OFD_BIT_W 3
`define OFD_LIT_W 8
`define OFD_PORT_A_ADDR 7'h05
`define OFD_OSC_PER_CYCLE 4
`define OFD_ACC_RESET 8'h00
`define OFD_OP_BYTE 2'h0
`define OFD_OP_BIT 2'h1
`define OFD_OP_LIT 2'h3
`define OFD_CLASS_LSB 12
`define OFD_CLASS_W 2
`define OFD_LIT_LSB 0
`define OFD_BOP_LSB 8
`define OFD_BOP_W 4
`define OFD_BITOP_LSB 10
`define OFD_BITOP_W 2
`define OFD_BOP_CLR 4'h1
`define OFD_BOP_AND 4'h5
`define OFD_BOP_ADD 4'h7
`define OFD_BOP_INC 4'hA
`define OFD_BITOP_CLR 2'h0
`define OFD_BITOP_SET 2'h1
`define OFD_BIT_ONE 8'h01
`endif

//--- logic/ofd_pkg.sv
// Types for the operand field decoder
`include "ofd_defs.svh"
package ofd_pkg;
	typedef enum logic [2:0] {
		OFD_ALU_PASS, OFD_ALU_CLR, OFD_ALU_BCLR, OFD_ALU_BSET,
		OFD_ALU_ADD, OFD_ALU_AND, OFD_ALU_INC, OFD_ALU_LIT
	} ofd_alu_t;
	typedef struct packed {
		logic [`OFD_FADDR_W-1:0] addr;
		logic [`OFD_DATA_W-1:0] data;
		logic we;
		logic re;
	} ofd_file_req_t;
endpackage

//--- logic/ofd_decode.sv
// Operand field decode and read-modify-write sequencer
//
// Overview of operation
// - File instructions read, modify, then store the result to chosen place; bit codes other than clear and set store nothing.
// - The named file register is read even for write-only instructions.
// - Clearing port A data reads it, zeroes it, writes back; read clears flag.
// - Seven-bit file address selects registers 0x00 through 0x7F.
// - Three-bit bit field picks one bit of the 8-bit file register.
// - Destination bit zero stores to accumulator, one to file register.
// - Don't-care instruction bits never affect execution.
// - Instructions are 14-bit words of opcode and operand fields.
// - Cycle is four clocks; taken branches add a no-op second cycle.
`timescale 1ns/1ps
module ofd_decode
	import ofd_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic insn_valid,
	input wire logic [`OFD_INSN_W-1:0] insn,
	input wire logic branch_taken,
	input wire logic [`OFD_DATA_W-1:0] file_rdata,
	output ofd_file_req_t file_req,
	output logic [`OFD_DATA_W-1:0] acc,
	output logic port_a_read,
	output logic insn_ready,
	output logic cycle_nop
);
	typedef enum logic [1:0] {OFD_Q_FETCH, OFD_Q_READ, OFD_Q_MOD, OFD_Q_STORE}
		ofd_q_t;
	ofd_q_t q_reg, q_next;
	logic [`OFD_INSN_W-1:0] ir_reg;
	logic [`OFD_DATA_W-1:0] res_reg;
	logic [`OFD_DATA_W-1:0] acc_reg;
	logic nop_reg;
	logic nop_pend_reg;
	ofd_file_req_t req_reg, req_next;
	logic pa_rd_reg;

	// Field decode
	wire [`OFD_CLASS_W-1:0] op_class;
	wire [`OFD_FADDR_W-1:0] f_addr;
	wire dest_file;
	wire [`OFD_BIT_W-1:0] bit_sel;
	wire [`OFD_LIT_W-1:0] lit;
	wire [`OFD_BOP_W-1:0] byte_op;
	wire [`OFD_BITOP_W-1:0] bit_op;
	assign op_class = ir_reg[`OFD_CLASS_LSB +: `OFD_CLASS_W];
	assign f_addr = ir_reg[`OFD_FADDR_LSB +: `OFD_FADDR_W];
	assign dest_file = ir_reg[`OFD_DEST_POS];
	assign bit_sel = ir_reg[`OFD_BIT_LSB +: `OFD_BIT_W];
	assign lit = ir_reg[`OFD_LIT_LSB +: `OFD_LIT_W];
	assign byte_op = ir_reg[`OFD_BOP_LSB +: `OFD_BOP_W];
	assign bit_op = ir_reg[`OFD_BITOP_LSB +: `OFD_BITOP_W];

	// Instruction class
	wire is_byte;
	wire is_bit;
	wire is_file;
	assign is_byte = op_class == `OFD_OP_BYTE;
	assign is_bit = op_class == `OFD_OP_BIT;
	assign is_file = is_byte || is_bit;

	// One-hot mask of the selected bit
	wire [`OFD_DATA_W-1:0] bit_mask;
	assign bit_mask = `OFD_BIT_ONE << bit_sel;

	// Operation selects; unused codes and bits fall through to a move
	wire sel_bclr;
	wire sel_bset;
	wire sel_clr;
	wire sel_and;
	wire sel_add;
	wire sel_inc;
	assign sel_bclr = is_bit && bit_op == `OFD_BITOP_CLR;
	assign sel_bset = is_bit && bit_op == `OFD_BITOP_SET;
	assign sel_clr = is_byte && byte_op == `OFD_BOP_CLR;
	assign sel_and = is_byte && byte_op == `OFD_BOP_AND;
	assign sel_add = is_byte && byte_op == `OFD_BOP_ADD;
	assign sel_inc = is_byte && byte_op == `OFD_BOP_INC;

	ofd_alu_t alu;
	assign alu = sel_bclr ? OFD_ALU_BCLR :
		sel_bset ? OFD_ALU_BSET :
		!is_file ? OFD_ALU_LIT :
		sel_clr ? OFD_ALU_CLR :
		sel_and ? OFD_ALU_AND :
		sel_add ? OFD_ALU_ADD :
		sel_inc ? OFD_ALU_INC : OFD_ALU_PASS;

	// Operand is the file word shown while the read strobe stands
	wire [`OFD_DATA_W-1:0] opnd;
	assign opnd = file_rdata;

	logic [`OFD_DATA_W-1:0] alu_out;
	always_comb begin
		case (alu)
			OFD_ALU_CLR: alu_out = 8'h00;
			OFD_ALU_BCLR: alu_out = opnd & ~bit_mask;
			OFD_ALU_BSET: alu_out = opnd | bit_mask;
			OFD_ALU_ADD: alu_out = opnd + acc_reg;
			OFD_ALU_AND: alu_out = opnd & acc_reg;
			OFD_ALU_INC: alu_out = opnd + `OFD_BIT_ONE;
			OFD_ALU_LIT: alu_out = lit;
			default: alu_out = opnd;
		endcase
	end

	// Bit clear and set store to file, other bit codes store nothing; byte ops follow destination bit
	wire store_file = is_bit || (is_byte && dest_file);
	wire wr_bit = is_bit && bit_op[1] == 1'b0;
	wire do_file_wr = is_byte ? dest_file : wr_bit;

	always_comb begin
		q_next = q_reg;
		req_next = '0;
		case (q_reg)
			OFD_Q_FETCH: q_next = OFD_Q_READ;
			OFD_Q_READ: begin
				q_next = OFD_Q_MOD;
				req_next.re = is_file;
				req_next.addr = f_addr;
			end
			OFD_Q_MOD: q_next = OFD_Q_STORE;
			OFD_Q_STORE: begin
				q_next = OFD_Q_FETCH;
				req_next.we = is_file && store_file && do_file_wr;
				req_next.addr = f_addr;
				req_next.data = res_reg;
			end
			default: q_next = OFD_Q_FETCH;
		endcase
	end

	wire q_fetch = q_reg == OFD_Q_FETCH;
	wire take_insn = q_fetch && insn_valid && !nop_pend_reg;
	wire acc_wr = q_reg == OFD_Q_STORE && !nop_reg &&
		(!is_file || (is_byte && !dest_file));
	wire pa_hit = q_reg == OFD_Q_READ && is_file && !nop_reg &&
		f_addr == `OFD_PORT_A_ADDR;

	// Four-clock instruction cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q_reg <= OFD_Q_FETCH;
		end else if (clk_en) begin
			q_reg <= q_next;
		end
	end

	// Instruction register loads only in the fetch phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ir_reg <= '0;
			nop_reg <= 1'b1;
		end else if (clk_en && q_fetch) begin
			ir_reg <= take_insn ? insn : '0;
			nop_reg <= !take_insn;
		end
	end

	// A taken branch turns the following cycle into a no-op
	wire branch_hit;
	assign branch_hit = q_reg == OFD_Q_STORE && branch_taken && !nop_reg;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			nop_pend_reg <= 1'b0;
		end else if (clk_en) begin
			if (branch_hit)
				nop_pend_reg <= 1'b1;
			else if (q_fetch)
				nop_pend_reg <= 1'b0;
		end
	end

	// File strobes and the port A read pulse
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_reg <= '0;
			pa_rd_reg <= 1'b0;
		end else if (clk_en) begin
			req_reg <= nop_reg ? '0 : req_next;
			pa_rd_reg <= pa_hit;
		end
	end

	// Result is formed at the end of the modify phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			res_reg <= '0;
		end else if (clk_en && q_reg == OFD_Q_MOD) begin
			res_reg <= alu_out;
		end
	end

	// Accumulator, written only in the store phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_reg <= `OFD_ACC_RESET;
		end else if (clk_en && acc_wr) begin
			acc_reg <= res_reg;
		end
	end

	// Fetch-phase marker; reset leaves the cycle in fetch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			insn_ready <= 1'b1;
			cycle_nop <= 1'b1;
		end else if (clk_en) begin
			insn_ready <= q_next == OFD_Q_FETCH;
			cycle_nop <= nop_reg;
		end
	end

	assign file_req = req_reg;
	assign acc = acc_reg;
	assign port_a_read = pa_rd_reg;
endmodule

//--- tb/ofd_file_model.sv
// Data file model facing the decoder
`timescale 1ns/1ps
module ofd_file_model
	import ofd_pkg::*;
(
	input wire logic clk,
	input ofd_file_req_t req,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:127];
	logic [7:0] last_q = 8'h00;
	// Word stands while the read strobe does; otherwise the inverse shows
	always_comb rdata = req.re ? mem[req.addr] : ~last_q;
	always @(posedge clk) begin
		if (req.re)
			last_q <= mem[req.addr];
		if (req.we)
			mem[req.addr] <= req.data;
	end
endmodule

//--- tb/ofd_decode_checker.sv
// Assertions on the decoder ports
`timescale 1ns/1ps
module ofd_decode_checker
	import ofd_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic insn_valid,
	input wire logic [13:0] insn,
	input wire logic branch_taken,
	input ofd_file_req_t file_req,
	input wire logic [7:0] acc,
	input wire logic port_a_read,
	input wire logic insn_ready,
	input wire logic cycle_nop
);
	default clocking @(posedge clk iff clk_en); endclocking
	default disable iff (!resetn);
	// Phase in the cycle and a pending no-op after a taken branch
	logic [1:0] ph_q;
	logic busy_q;
	logic skip_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ph_q <= 2'h0;
			busy_q <= 1'b0;
			skip_q <= 1'b0;
		end else if (clk_en) begin
			ph_q <= insn_ready ? 2'h1 : ph_q + 2'h1;
			if (insn_ready) begin
				busy_q <= insn_valid && !skip_q;
				skip_q <= 1'b0;
			end else if (ph_q == 2'h3 && branch_taken && busy_q) begin
				skip_q <= 1'b1;
			end
		end
	end
	wire tk = insn_ready && insn_valid && !skip_q;
	wire fo = tk && !insn[13];
	wire bo = tk && insn[13:12] == 2'h0;
	sequence rd_s;
		##2 file_req.re && !file_req.we;
	endsequence
	sequence st_s;
		##4 file_req.we;
	endsequence
	rd_first_a: assert property (fo |-> rd_s)
		else $error("file not read");
	rd_addr_a: assert property (
		fo |-> ##2 file_req.addr == $past(insn[6:0], 2))
		else $error("wrong file address");
	port_read_a: assert property (
		file_req.re && file_req.addr == 7'h05 |-> port_a_read)
		else $error("port read not flagged");
	dest_file_a: assert property (bo && insn[7] |-> st_s)
		else $error("no file store");
	dest_acc_a: assert property (
		bo && !insn[7] |-> ##4 !file_req.we)
		else $error("stray file store");
	clr_zero_a: assert property (
		bo && insn[11:7] == 5'h03 |-> ##4 file_req.data == 8'h00)
		else $error("clear not zero");
	bit_set_a: assert property (
		tk && insn[13:10] == 4'h5 |->
		##4 file_req.we && file_req.data[$past(insn[9:7], 4)])
		else $error("bit not set");
	cycle_len_a: assert property (tk |=> !insn_ready [*3])
		else $error("cycle too short");
	acc_hold_a: assert property ($changed(acc) |-> $past(tk, 4))
		else $error("acc changed early");
	nop_cycle_a: assert property (
		insn_ready && skip_q |-> ##2 cycle_nop)
		else $error("branch shadow not a no-op");
	nop_read_a: assert property (
		insn_ready && skip_q |-> ##2 !file_req.re)
		else $error("no-op cycle read the file");
	live_cycle_a: assert property (tk |-> ##2 !cycle_nop)
		else $error("taken word marked no-op");
endmodule
bind ofd_decode ofd_decode_checker i_chk (.clk(clk), .resetn(resetn),
	.clk_en(clk_en), .insn_valid(insn_valid), .insn(insn),
	.branch_taken(branch_taken), .file_req(file_req), .acc(acc),
	.port_a_read(port_a_read), .insn_ready(insn_ready),
	.cycle_nop(cycle_nop));

//--- tb/test_operand_field_decode_rmw.sv
// Testbench for the operand field decoder
`timescale 1ns/1ps
module test_operand_field_decode_rmw
	import ofd_pkg::*;
;
	logic clk = 0, resetn = 0, insn_valid = 0;
	logic branch_taken = 0, clk_en = 1;
	logic [13:0] insn = 14'h0000;
	ofd_file_req_t file_req;
	logic [7:0] file_rdata, acc;
	logic port_a_read, insn_ready, cycle_nop;
	int err_count = 0, cmp_count = 0, cyc = 0, pa = 0;
	always #4 clk = ~clk;
	ofd_decode i_dut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
		.insn_valid(insn_valid), .insn(insn), .branch_taken(branch_taken),
		.file_rdata(file_rdata), .file_req(file_req), .acc(acc),
		.port_a_read(port_a_read), .insn_ready(insn_ready),
		.cycle_nop(cycle_nop));
	ofd_file_model m (.clk(clk), .req(file_req), .rdata(file_rdata));
	task check(input string n, input logic [7:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task summarize;
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		pa = pa + port_a_read;
		if (cyc == 2000) begin
			err_count++;
			summarize;
		end
	end
	// Offer one word, wait for its take, let it finish
	task run(input logic [13:0] w);
		insn <= w;
		insn_valid <= 1;
		do @(negedge clk); while (!insn_ready);
		@(posedge clk);
		insn_valid <= 0;
		repeat (6) @(posedge clk);
	endtask
	task t_clr;
		pa = 0;
		m.mem[5] = 8'ha5;
		run(14'h0185);
		check("port", m.mem[5], 8'h00);
		check("pa", pa[7:0], 8'h01);
	endtask
	task t_dest;
		m.mem[127] = 8'h3c;
		run(14'h007f);
		check("accw", acc, 8'h3c);
		run(14'h0aff);
		check("inc", m.mem[127], 8'h3d);
		check("acck", acc, 8'h3c);
	endtask
	task t_bit;
		m.mem[0] = 8'h7f;
		run(14'h1780);
		check("set", m.mem[0], 8'hff);
		run(14'h1000);
		check("clr", m.mem[0], 8'hfe);
	endtask
	// Branch shadow refuses the word offered; it is taken one cycle later
	task t_branch;
		m.mem[1] = 8'h11;
		insn <= 14'h0081;
		insn_valid <= 1;
		branch_taken <= 1;
		do @(negedge clk); while (!insn_ready);
		@(posedge clk);
		insn <= 14'h0a81;
		repeat (4) @(posedge clk);
		branch_taken <= 0;
		repeat (2) @(negedge clk);
		check("nop", cycle_nop, 8'h01);
		repeat (3) @(posedge clk);
		insn_valid <= 0;
		repeat (2) @(negedge clk);
		check("live", cycle_nop, 8'h00);
		repeat (4) @(posedge clk);
		check("once", m.mem[1], 8'h12);
	endtask
	// Clock enable low freezes a word in flight
	task t_freeze;
		logic [7:0] a;
		a = acc;
		m.mem[2] = 8'h40;
		insn <= 14'h0002;
		insn_valid <= 1;
		do @(negedge clk); while (!insn_ready);
		@(posedge clk);
		insn_valid <= 0;
		clk_en <= 0;
		repeat (5) @(posedge clk);
		check("hold", acc, a);
		check("frz", insn_ready, 8'h00);
		clk_en <= 1;
		repeat (6) @(posedge clk);
		check("accw2", acc, 8'h40);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1;
		t_clr;
		t_dest;
		t_bit;
		t_branch;
		t_freeze;
		summarize;
	end
endmodule
